// ===== logic/i2cs_pkg.sv
package i2cs_pkg;

    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int SYS_CLK_NS = 10;
    localparam int LINK_CLK_NS = 32;
    localparam int HOLD_LONG_NS = 300;
    // least time, so round up to whole link cycles
    localparam int HOLD_LONG_CYC_I =
        (HOLD_LONG_NS + LINK_CLK_NS - 1) / LINK_CLK_NS;
    localparam logic [3:0] HOLD_LONG_CYC = 4'(HOLD_LONG_CYC_I);
    localparam logic [3:0] HOLD_SHORT_CYC = 4'h1;

    // ---------------------------------------------------------------
    // byte framing and address layout
    // ---------------------------------------------------------------
    localparam logic [3:0] BIT_DATA_END = 4'h8;
    localparam logic [3:0] BIT_ACK_END = 4'h9;
    localparam logic [4:0] TEN_BIT_HEAD = 5'h1e;
    localparam int TEN_HI_MSB = 2;
    localparam int TEN_HI_LSB = 1;

    // ---------------------------------------------------------------
    // types
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_ADDR7, MODE_ADDR10, MODE_ADDR7_SP, MODE_ADDR10_SP
    } i2cs_mode_t;

    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_ADDR_LO, ST_RX, ST_TX
    } i2cs_state_t;

    // software control bits, quasi-static
    typedef struct packed {
        i2cs_mode_t port_mode_select;
        logic address_hold_enable;
        logic data_hold_enable;
        logic ack_data_value;
        logic sda_hold_long_sel;
        logic start_irq_enable;
        logic stop_irq_enable;
        logic buffer_full_flag;
        logic receive_overflow_flag;
        logic start_gen;
        logic [7:0] slave_address_reg;
        logic [7:0] address_high_reg;
        logic [7:0] address_mask;
    } i2cs_cfg_t;

    // status levels as seen on the system clock
    typedef struct packed {
        logic received_ack_status;
        logic ack_time_status;
        logic read_request;
        logic bus_active;
        logic bus_idle;
    } i2cs_status_t;

endpackage

// ===== logic/i2cs_slave.sv
`timescale 1ns/1ps
module i2cs_slave
    import i2cs_pkg::*;
(
    // system side
    input wire logic sys_clk,
    input wire logic rst,
    // link side, free-running sampling clock of the bus logic
    input wire logic link_clk,
    // bus pins, enables low while driving
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_n,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n,
    // software control
    input wire i2cs_cfg_t cfg,
    input wire logic clk_release,
    input wire logic [7:0] tx_data,
    input wire logic irq_clear,
    input wire logic collision_clear,
    // software status
    output logic port_irq_flag,
    output logic bus_collision_flag,
    output logic [7:0] rx_byte,
    output logic rx_load,
    output i2cs_status_t status
);

    // ---------------------------------------------------------------
    // state of both domains
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [1:0] scl_sy;
        logic [1:0] sda_sy;
        logic scl_p;
        logic sda_p;
        i2cs_cfg_t cfg_s1;
        i2cs_cfg_t cfg_s2;
        logic [2:0] rel_sy;
        logic start_p;
        i2cs_state_t st;
        logic active;
        logic idle;
        logic scl_low_seen;
        logic [3:0] bits;
        logic [7:0] shreg;
        logic [7:0] tx_sh;
        logic tx_first;
        logic rw;
        logic prior_match;
        logic ack_pend;
        logic ack_time;
        logic ack_stat;
        logic scl_oe_n;
        logic sda_oe_n;
        logic sda_nx;
        logic [3:0] hold_cnt;
        logic [7:0] rx_word;
        logic irq_tgl;
        logic coll_tgl;
        logic load_tgl;
    } i2cs_link_t;

    typedef struct packed {
        logic [2:0] irq_sy;
        logic [2:0] coll_sy;
        logic [2:0] load_sy;
        i2cs_status_t st_s1;
        i2cs_status_t st_s2;
        logic rel_tgl;
        logic [7:0] tx_hold;
        logic irq_flag;
        logic coll_flag;
        logic [7:0] rx_byte;
        logic rx_load;
    } i2cs_sys_t;

    i2cs_link_t l_q, l_d;
    i2cs_sys_t s_q, s_d;

    // ---------------------------------------------------------------
    // link-side decode
    // ---------------------------------------------------------------
    logic scl, sda, scl_rise, scl_fall, start_c, stop_c, release_ev;
    logic hold_en, ten_bit, sp_mode, no_room;
    logic m7, hi10, lo10;
    logic [7:0] cmask;
    i2cs_cfg_t c;

    // only the second synchroniser stage is looked at
    assign scl = l_q.scl_sy[1];
    assign sda = l_q.sda_sy[1];
    assign c = l_q.cfg_s2;
    assign scl_rise = scl & ~l_q.scl_p;
    assign scl_fall = ~scl & l_q.scl_p;
    assign start_c = scl & l_q.scl_p & l_q.sda_p & ~sda;
    // a low-then-high SDA blip with SCL high all along is no Stop
    assign stop_c = scl & l_q.scl_p & ~l_q.sda_p & sda
        & l_q.scl_low_seen;
    assign release_ev = l_q.rel_sy[2] ^ l_q.rel_sy[1];
    assign hold_en = c.address_hold_enable | c.data_hold_enable;
    assign ten_bit = c.port_mode_select == MODE_ADDR10
        || c.port_mode_select == MODE_ADDR10_SP;
    assign sp_mode = c.port_mode_select == MODE_ADDR7_SP
        || c.port_mode_select == MODE_ADDR10_SP;
    assign no_room = c.buffer_full_flag | c.receive_overflow_flag;
    assign cmask = c.address_mask; // set bit = bit is compared
    assign m7 = ((l_q.shreg ^ c.slave_address_reg) & cmask & 8'hfe)
        == 8'h00;
    assign hi10 = l_q.shreg[7:1] == {TEN_BIT_HEAD,
        c.address_high_reg[TEN_HI_MSB:TEN_HI_LSB]};
    assign lo10 = ((l_q.shreg ^ c.slave_address_reg) & cmask)
        == 8'h00;

    // ---------------------------------------------------------------
    // link-side next state
    // ---------------------------------------------------------------
    always_comb begin
        l_d = l_q;
        l_d.scl_sy = {l_q.scl_sy[0], scl_i};
        l_d.sda_sy = {l_q.sda_sy[0], sda_i};
        l_d.scl_p = scl;
        l_d.sda_p = sda;
        l_d.cfg_s1 = cfg;
        l_d.cfg_s2 = l_q.cfg_s1;
        l_d.rel_sy = {l_q.rel_sy[1:0], s_q.rel_tgl};
        l_d.start_p = c.start_gen;
        l_d.idle = ~l_q.active & scl & sda;
        if (!scl) begin
            l_d.scl_low_seen = 1'b1;
        end
        // delayed SDA change keeps data valid past the SCL fall
        if (l_q.hold_cnt != 4'h0) begin
            l_d.hold_cnt = l_q.hold_cnt - 4'h1;
            if (l_q.hold_cnt == 4'h1) begin
                l_d.sda_oe_n = ~l_q.sda_nx;
            end
        end
        // own Start: the line must still be high before pulling it
        if (c.start_gen && !l_q.start_p) begin
            if (!sda) begin
                l_d.coll_tgl = ~l_q.coll_tgl;
            end else begin
                l_d.sda_oe_n = 1'b0;
            end
        end else if (!c.start_gen && l_q.start_p) begin
            l_d.sda_oe_n = 1'b1;
        end
        // rising SCL: sample data, acknowledge, check arbitration
        if (scl_rise && l_q.st != ST_IDLE) begin
            if (l_q.bits < BIT_DATA_END) begin
                l_d.shreg = {l_q.shreg[6:0], sda};
                if (l_q.st == ST_TX && l_q.sda_oe_n && !sda) begin
                    l_d.coll_tgl = ~l_q.coll_tgl;
                    l_d.st = ST_IDLE;
                    l_d.scl_oe_n = 1'b1;
                    l_d.hold_cnt = 4'h0;
                end
            end else if (l_q.st == ST_TX) begin
                l_d.ack_stat = sda;
            end
            if (l_q.bits < BIT_ACK_END) begin
                l_d.bits = l_q.bits + 4'h1;
            end
        end
        // falling SCL: byte end, ack slot end, next transmit bit
        if (scl_fall && l_q.st != ST_IDLE) begin
            l_d.hold_cnt = c.sda_hold_long_sel ? HOLD_LONG_CYC
                : HOLD_SHORT_CYC;
            if (l_q.bits == BIT_DATA_END) begin
                l_d.sda_nx = 1'b0; // release unless acking below
                case (l_q.st)
                    ST_ADDR: begin
                        l_d.rw = l_q.shreg[0];
                        if (!ten_bit) begin
                            l_d.st = !m7 ? ST_IDLE
                                : (l_q.shreg[0] ? ST_TX : ST_RX);
                        end else if (!hi10) begin
                            l_d.prior_match = 1'b0;
                            l_d.st = ST_IDLE;
                        end else if (!l_q.shreg[0]) begin
                            l_d.prior_match = 1'b0;
                            l_d.st = ST_ADDR_LO;
                        end else begin
                            // read only after a full write match
                            l_d.st = l_q.prior_match ? ST_TX
                                : ST_IDLE;
                        end
                    end
                    ST_ADDR_LO: begin
                        l_d.st = lo10 ? ST_RX : ST_IDLE;
                        l_d.prior_match = lo10;
                    end
                    default: begin
                    end
                endcase
                // receiving side of the byte: load and acknowledge
                if (l_d.st != ST_IDLE && l_q.st != ST_TX) begin
                    l_d.rx_word = l_q.shreg;
                    l_d.load_tgl = ~l_q.load_tgl;
                    l_d.irq_tgl = ~l_q.irq_tgl;
                    l_d.tx_first = l_d.st == ST_TX;
                    if (hold_en) begin
                        // stall so software can choose the answer
                        l_d.ack_time = 1'b1;
                        l_d.ack_pend = 1'b1;
                        l_d.scl_oe_n = 1'b0;
                    end else begin
                        l_d.sda_nx = ~no_room;
                    end
                end
            end else if (l_q.bits == BIT_ACK_END) begin
                l_d.bits = 4'h0;
                l_d.ack_time = 1'b0;
                l_d.sda_nx = 1'b0;
                if (l_q.st == ST_TX) begin
                    if (l_q.tx_first || !l_q.ack_stat) begin
                        // wait for the next byte from software
                        l_d.scl_oe_n = 1'b0;
                        if (!l_q.tx_first) begin
                            l_d.irq_tgl = ~l_q.irq_tgl;
                        end
                    end else begin
                        l_d.st = ST_IDLE; // nack ends the read
                    end
                end
            end else if (l_q.st == ST_TX) begin
                l_d.sda_nx = ~l_q.tx_sh[7];
                l_d.tx_sh = {l_q.tx_sh[6:0], 1'b0};
            end
        end
        // software release of a stalled clock
        if (release_ev && !l_q.scl_oe_n) begin
            l_d.scl_oe_n = 1'b1;
            l_d.hold_cnt = 4'h0;
            if (l_q.ack_pend) begin
                l_d.ack_pend = 1'b0;
                l_d.sda_oe_n = c.ack_data_value | no_room;
            end else if (l_q.st == ST_TX) begin
                // SCL is held low, so the first bit is safe now
                l_d.sda_oe_n = s_q.tx_hold[7];
                l_d.tx_sh = {s_q.tx_hold[6:0], 1'b0};
                l_d.tx_first = 1'b0;
            end
        end
        // Start and Restart reset the state, bit count, ack and clock hold; prior_match, rw, ack_stat and the SDA enable are kept
        if (start_c) begin
            l_d.st = ST_ADDR;
            l_d.active = 1'b1;
            l_d.bits = 4'h0;
            l_d.scl_low_seen = 1'b0;
            l_d.ack_pend = 1'b0;
            l_d.ack_time = 1'b0;
            l_d.tx_first = 1'b0;
            l_d.scl_oe_n = 1'b1;
            l_d.hold_cnt = 4'h0;
            if (sp_mode || c.start_irq_enable) begin
                l_d.irq_tgl = ~l_q.irq_tgl;
            end
        end else if (stop_c) begin
            l_d.st = ST_IDLE;
            l_d.active = 1'b0;
            l_d.prior_match = 1'b0;
            l_d.ack_pend = 1'b0;
            l_d.ack_time = 1'b0;
            l_d.scl_oe_n = 1'b1;
            l_d.sda_oe_n = 1'b1;
            l_d.hold_cnt = 4'h0;
            if (sp_mode || c.stop_irq_enable) begin
                l_d.irq_tgl = ~l_q.irq_tgl;
            end
        end
    end

    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            l_q <= '0;
            l_q.scl_sy <= 2'h3;
            l_q.sda_sy <= 2'h3;
            l_q.scl_p <= 1'b1;
            l_q.sda_p <= 1'b1;
            l_q.scl_oe_n <= 1'b1;
            l_q.sda_oe_n <= 1'b1;
            l_q.st <= ST_IDLE;
        end else begin
            l_q <= l_d;
        end
    end

    // ---------------------------------------------------------------
    // system-side next state
    // ---------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.irq_sy = {s_q.irq_sy[1:0], l_q.irq_tgl};
        s_d.coll_sy = {s_q.coll_sy[1:0], l_q.coll_tgl};
        s_d.load_sy = {s_q.load_sy[1:0], l_q.load_tgl};
        s_d.st_s1 = '{received_ack_status: l_q.ack_stat,
            ack_time_status: l_q.ack_time, read_request: l_q.rw,
            bus_active: l_q.active, bus_idle: l_q.idle};
        s_d.st_s2 = s_q.st_s1;
        if (clk_release) begin
            s_d.rel_tgl = ~s_q.rel_tgl;
            s_d.tx_hold = tx_data;
        end
        // sticky flags: a new event beats a clear in the same cycle
        if (irq_clear) begin
            s_d.irq_flag = 1'b0;
        end
        if (s_q.irq_sy[2] ^ s_q.irq_sy[1]) begin
            s_d.irq_flag = 1'b1;
        end
        if (collision_clear) begin
            s_d.coll_flag = 1'b0;
        end
        if (s_q.coll_sy[2] ^ s_q.coll_sy[1]) begin
            s_d.coll_flag = 1'b1;
        end
        // the byte stays put for a whole bit time, long after the toggle
        s_d.rx_load = s_q.load_sy[2] ^ s_q.load_sy[1];
        if (s_d.rx_load) begin
            s_d.rx_byte = l_q.rx_word;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign scl_o = 1'b0; // open drain: only ever pulls low
    assign sda_o = 1'b0;
    assign scl_oe_n = l_q.scl_oe_n;
    assign sda_oe_n = l_q.sda_oe_n;
    assign port_irq_flag = s_q.irq_flag;
    assign bus_collision_flag = s_q.coll_flag;
    assign rx_byte = s_q.rx_byte;
    assign rx_load = s_q.rx_load;
    assign status = s_q.st_s2;

endmodule

// ===== test/i2cs_props.sv
`timescale 1ns/1ps
module i2cs_props
    import i2cs_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // resolved bus lines and pin enables
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic scl_oe_n,
    input wire logic sda_oe_n,
    // software side
    input wire i2cs_cfg_t cfg,
    input wire logic port_irq_flag,
    input wire logic bus_collision_flag,
    input wire logic rx_load,
    input wire i2cs_status_t status
);
    // ----
    // helpers
    // ----
    logic low_seen_q;
    logic full_any;

    // a stop only counts once scl went low after the start
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            low_seen_q <= 1'b0;
        end else if (!scl_i) begin
            low_seen_q <= 1'b1;
        end else if ($fell(sda_i)) begin
            low_seen_q <= 1'b0;
        end
    end
    assign full_any = cfg.buffer_full_flag | cfg.receive_overflow_flag;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    // ----
    // properties; windows allow for the 2FF paths both ways
    // ----
    a_start_active: assert property (
        $fell(sda_i) && scl_i |-> ##[1:24] status.bus_active)
        else $error("start not seen as bus active");
    a_stop_idle: assert property (
        $rose(sda_i) && scl_i && low_seen_q |-> ##[1:24] !status.bus_active)
        else $error("stop did not end activity");
    a_early_stop: assert property (
        $rose(sda_i) && scl_i && !low_seen_q && status.bus_active
        |=> status.bus_active [*8])
        else $error("stop taken without scl low");
    a_own_clash: assert property (
        $rose(cfg.start_gen) && !sda_i |-> ##[1:24] bus_collision_flag)
        else $error("own start over low sda not flagged");
    a_full_nack: assert property (
        full_any && $past(full_any, 8) && !status.read_request |-> sda_oe_n)
        else $error("sda driven while buffer full");
    a_acktime_mode: assert property (
        status.ack_time_status |->
        cfg.address_hold_enable || cfg.data_hold_enable)
        else $error("ack time flag outside hold modes");
    a_acktime_hold: assert property (
        $rose(status.ack_time_status) |-> !scl_oe_n)
        else $error("ack time without clock hold");
    a_load_irq: assert property (
        rx_load |-> ##[0:4] port_irq_flag)
        else $error("loaded byte raised no interrupt");
    a_idle_inactive: assert property (
        status.bus_idle |-> !status.bus_active)
        else $error("idle reported while active");
    a_sp_irq: assert property (
        cfg.port_mode_select == MODE_ADDR7_SP && $rose(status.bus_active)
        |-> ##[0:6] port_irq_flag)
        else $error("start in irq mode raised no interrupt");
    c_load: cover property (rx_load);
    c_acktime: cover property ($rose(status.ack_time_status));
    c_clash: cover property ($rose(bus_collision_flag));
endmodule

bind i2cs_slave i2cs_props u_props (
    .sys_clk(sys_clk),
    .rst(rst),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .scl_oe_n(scl_oe_n),
    .sda_oe_n(sda_oe_n),
    .cfg(cfg),
    .port_irq_flag(port_irq_flag),
    .bus_collision_flag(bus_collision_flag),
    .rx_load(rx_load),
    .status(status)
);

// ===== test/i2cs_master.sv
`timescale 1ns/1ps
module i2cs_master (
    // link clock and resolved lines
    input wire logic link_clk,
    input wire logic scl_line,
    input wire logic sda_line,
    // 0 pulls the line low, 1 leaves it to the pull-up
    output logic scl_rel,
    output logic sda_rel
);
    // half bit; long enough for sync plus the long sda hold
    localparam int Q = 16;

    // bus idle, both lines released
    initial begin
        scl_rel = 1'b1;
        sda_rel = 1'b1;
    end

    // set both lines just after an edge, then let n cycles pass
    task automatic pins(input logic c, input logic d, input int n);
        @(posedge link_clk);
        #2;
        scl_rel = c;
        sda_rel = d;
        repeat (n) @(posedge link_clk);
    endtask

    // one bit; waits out a stretch, bounded so a hang cannot stick
    task automatic bit_cyc(input logic d, output logic s);
        int w;
        pins(1'b0, d, Q);
        pins(1'b1, d, 1);
        w = 0;
        while (!scl_line && w < 4000) begin
            @(posedge link_clk);
            w++;
        end
        repeat (Q) @(posedge link_clk);
        s = sda_line;
        pins(1'b0, d, 0);
    endtask

    // start or restart; sda rises only while scl is low
    task automatic start();
        pins(scl_rel, 1'b1, 2 * Q);
        pins(1'b1, 1'b1, 2 * Q);
        pins(1'b1, 1'b0, 2 * Q);
        pins(1'b0, 1'b0, Q);
    endtask

    task automatic stop();
        pins(1'b0, 1'b0, Q);
        pins(1'b1, 1'b0, 2 * Q);
        pins(1'b1, 1'b1, 4 * Q);
    endtask

    // byte out MSB first, then sda freed for the answer
    task automatic wr_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_cyc(b[i], s);
        end
        bit_cyc(1'b1, ack);
    endtask

    task automatic rd_byte(input logic ack, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_cyc(1'b1, s);
            b[i] = s;
        end
        bit_cyc(ack, s);
    endtask
endmodule

// ===== test/i2c_slave_condition_ack_addr_bench.sv
`timescale 1ns/1ps
module i2c_slave_condition_ack_addr_bench
    import i2cs_pkg::*;
;
    typedef struct packed {
        i2cs_mode_t mode;
        logic [7:0] mask;
        logic [7:0] hi;
        logic [7:0] byt;
        logic full;
        logic ovf;
        logic ack;
    } i2cs_case_t;

    logic sys_clk = 1'b0;
    logic link_clk = 1'b0;
    logic rst = 1'b1;
    logic clk_release = 1'b0;
    logic irq_clear = 1'b0;
    logic collision_clear = 1'b0;
    logic [7:0] tx_data = 8'h00;
    i2cs_cfg_t cfg;
    logic scl_o, scl_oe_n, sda_o, sda_oe_n, m_scl, m_sda, scl, sda;
    logic port_irq_flag, bus_collision_flag, rx_load;
    logic [7:0] rx_byte;
    i2cs_status_t status;
    int n_fail = 0;
    int checked = 0;
    int cyc = 0;
    int rx_cnt = 0;

    // clocks, unrelated in phase
    always #5 sys_clk = ~sys_clk;
    always #16 link_clk = ~link_clk;

    // open-drain lines with pull-ups
    assign scl = m_scl & (scl_oe_n | scl_o);
    assign sda = m_sda & (sda_oe_n | sda_o);

    i2cs_slave dut (.sys_clk(sys_clk), .rst(rst), .link_clk(link_clk),
        .scl_i(scl), .scl_o(scl_o), .scl_oe_n(scl_oe_n), .sda_i(sda),
        .sda_o(sda_o), .sda_oe_n(sda_oe_n), .cfg(cfg),
        .clk_release(clk_release), .tx_data(tx_data),
        .irq_clear(irq_clear), .collision_clear(collision_clear),
        .port_irq_flag(port_irq_flag),
        .bus_collision_flag(bus_collision_flag), .rx_byte(rx_byte),
        .rx_load(rx_load), .status(status));

    i2cs_master m (.link_clk(link_clk), .scl_line(scl), .sda_line(sda),
        .scl_rel(m_scl), .sda_rel(m_sda));

    // ----
    // helpers
    // ----
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic clr_irq();
        tick(1);
        irq_clear = 1'b1;
        tick(1);
        irq_clear = 1'b0;
        rx_cnt = 0;
    endtask

    task automatic release_clk(input logic [7:0] d);
        tick(1);
        tx_data = d;
        clk_release = 1'b1;
        tick(1);
        clk_release = 0;
    endtask

    // rx_load is a one-cycle pulse, so count it as it passes
    always @(posedge sys_clk) begin
        if (rx_load === 1'b1) begin
            rx_cnt++;
        end
        cyc++;
        if (cyc == 60000) begin
            n_fail++;
            $display("ERROR %0t run timed out", $time);
            close_out();
        end
    end

    // ----
    // scenarios
    // ----
    task automatic t_table();
        i2cs_case_t tbl [7];
        logic a;
        tbl = '{'{MODE_ADDR7, 8'hff, 8'h00, 8'h42, 1'b0, 1'b0, 1'b1},
            '{MODE_ADDR7, 8'hff, 8'h00, 8'h44, 1'b0, 1'b0, 1'b0},
            '{MODE_ADDR7, 8'hfb, 8'h00, 8'h46, 1'b0, 1'b0, 1'b1},
            '{MODE_ADDR7, 8'hff, 8'h00, 8'h42, 1'b1, 1'b0, 1'b0},
            '{MODE_ADDR7, 8'hff, 8'h00, 8'h42, 1'b0, 1'b1, 1'b0},
            '{MODE_ADDR10, 8'hff, 8'h06, 8'hf6, 1'b0, 1'b0, 1'b1},
            '{MODE_ADDR10, 8'hff, 8'h06, 8'hf2, 1'b0, 1'b0, 1'b0}};
        foreach (tbl[i]) begin
            tick(1);
            cfg.port_mode_select = tbl[i].mode;
            cfg.address_mask = tbl[i].mask;
            cfg.address_high_reg = tbl[i].hi;
            cfg.buffer_full_flag = tbl[i].full;
            cfg.receive_overflow_flag = tbl[i].ovf;
            clr_irq();
            m.start();
            m.wr_byte(tbl[i].byt, a);
            tick(10);
            chk(a, !tbl[i].ack);
            if (!tbl[i].full && !tbl[i].ovf) begin
                chk(port_irq_flag, tbl[i].ack);
                chk(8'(rx_cnt), tbl[i].ack);
            end
            m.stop();
        end
        tick(1);
        cfg = '0;
        cfg.slave_address_reg = 8'h43;
        cfg.address_mask = 8'hff;
    endtask

    task automatic t_sp();
        logic a;
        cfg.port_mode_select = MODE_ADDR7_SP;
        clr_irq();
        m.start();
        tick(30);
        chk(port_irq_flag, 1'b1);
        clr_irq();
        m.wr_byte(8'h42, a);
        m.wr_byte(8'h5a, a);
        tick(10);
        chk(a, 1'b0);
        chk(rx_byte, 8'h5a);
        clr_irq();
        m.start();
        tick(30);
        chk(port_irq_flag, 1'b1);
        m.wr_byte(8'h44, a);
        chk(a, 1'b1);
        clr_irq();
        m.stop();
        tick(30);
        chk(port_irq_flag, 1'b1);
        chk(status.bus_idle, 1'b1);
        cfg.port_mode_select = MODE_ADDR7;
    endtask

    // software acknowledge, both values, with the long sda hold
    task automatic t_hold();
        logic a;
        int w;
        cfg.address_hold_enable = 1'b1;
        cfg.sda_hold_long_sel = 1'b1;
        for (int v = 0; v < 2; v++) begin
            tick(1);
            cfg.ack_data_value = v[0];
            m.start();
            fork
                m.wr_byte(8'h42, a);
                begin
                    w = 0;
                    while (status.ack_time_status !== 1'b1 && w < 3000) begin
                        tick(1);
                        w++;
                    end
                    chk(status.ack_time_status, 1'b1);
                    chk(scl_oe_n, 1'b0);
                    release_clk(8'h00);
                end
            join
            chk(a, v[0]);
            m.stop();
        end
        tick(1);
        cfg.address_hold_enable = 1'b0;
    endtask

    // sda dips and returns with scl high throughout
    task automatic t_early();
        m.pins(1'b1, 1'b0, 32);
        m.pins(1'b1, 1'b1, 32);
        tick(1);
        chk(status.bus_active, 1'b1);
        m.pins(1'b0, 1'b1, 16);
        m.stop();
        tick(30);
        chk(status.bus_active, 1'b0);
    endtask

    task automatic t_read();
        logic a;
        logic [7:0] d;
        m.start();
        m.wr_byte(8'h43, a);
        tick(10);
        chk(a, 1'b0);
        chk(status.read_request, 1'b1);
        fork
            m.rd_byte(1'b1, d);
            begin
                tick(40);
                chk(scl_oe_n, 1'b0);
                release_clk(8'ha5);
            end
        join
        tick(10);
        chk(d, 8'ha5);
        chk(status.received_ack_status, 1'b1);
        m.stop();
    endtask

    // 10-bit read after a full write match; the master then pulls
    // sda low under a released data bit, which must read as a clash
    task automatic t_ten();
        logic a;
        cfg.port_mode_select = MODE_ADDR10;
        cfg.address_high_reg = 8'h06;
        m.start();
        m.wr_byte(8'hf6, a);
        m.wr_byte(8'h43, a);
        chk(a, 1'b0);
        m.start();
        m.wr_byte(8'hf7, a);
        tick(10);
        chk(a, 1'b0);
        chk(status.read_request, 1'b1);
        release_clk(8'hff);
        m.stop();
        tick(10);
        chk(bus_collision_flag, 1'b1);
        chk(status.bus_active, 1'b0);
        collision_clear = 1'b1;
        tick(1);
        collision_clear = 1'b0;
        cfg.port_mode_select = MODE_ADDR7;
    endtask

    task automatic t_clash();
        m.pins(1'b1, 1'b0, 16);
        tick(1);
        cfg.start_gen = 1'b1;
        tick(30);
        chk(bus_collision_flag, 1'b1);
        cfg.start_gen = 1'b0;
        collision_clear = 1'b1;
        tick(1);
        collision_clear = 1'b0;
        m.pins(1'b0, 1'b0, 16);
        m.stop();
        tick(1);
        chk(bus_collision_flag, 1'b0);
        cfg.start_gen = 1'b1;
        tick(30);
        chk(sda_oe_n, 1'b0);
        chk(bus_collision_flag, 1'b0);
        cfg.start_gen = 1'b0;
        tick(30);
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        cfg = '0;
        cfg.slave_address_reg = 8'h43;
        cfg.address_mask = 8'hff;
        tick(20);
        chk({scl_oe_n, sda_oe_n, port_irq_flag, bus_collision_flag, 4'h0},
            8'hc0);
        chk(8'(status), 8'h00);
        chk(rx_byte, 8'h00);
        rst = 1'b0;
        tick(20);
        chk(status.bus_idle, 1'b1);
        t_table();
        t_sp();
        t_hold();
        t_early();
        t_read();
        t_ten();
        t_clash();
        close_out();
    end
endmodule
